// ---- timekeeping_pkg.sv ----
// Shared constants for the program timekeeping unit.
package timekeeping_pkg;

  // Sizes.
  localparam int NUM_COUNTERS = 4;
  localparam int NUM_BASES = 4;
  localparam int COUNT_W = 8;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;

  // Register byte offsets.
  localparam logic [7:0] OFS_PRESET0 = 8'h00;
  localparam logic [7:0] OFS_PRESET1 = 8'h04;
  localparam logic [7:0] OFS_PRESET2 = 8'h08;
  localparam logic [7:0] OFS_PRESET3 = 8'h0c;
  localparam logic [7:0] OFS_BRANCH = 8'h10;
  localparam logic [7:0] OFS_TIME = 8'h14;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h18;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h1c;
  localparam logic [7:0] OFS_LEVEL_ENABLE = 8'h20;
  localparam logic [7:0] OFS_VECTOR = 8'h24;
  localparam logic [7:0] OFS_CLOCK_CTRL = 8'h28;

  // Field positions.
  localparam int PRESET_SEL_BIT = 8;
  localparam int PRESET_IRQ_BIT = 9;
  localparam int PRESET_DONE_BIT = 16;
  localparam int BRANCH_VALID_BIT = 4;
  localparam int VECTOR_VALID_BIT = 3;
  localparam int CLOCK_SECRESET_BIT = 0;

  // Reset values.
  localparam logic [COUNT_W-1:0] COUNT_RESET = 8'h00;
  localparam logic [3:0] MASK_RESET = 4'h0;
  localparam logic [1:0] LEVEL_RESET = 2'h0;

  // Time base indices.
  localparam logic [1:0] BASE_3MS = 2'h0;
  localparam logic [1:0] BASE_17MS = 2'h1;
  localparam logic [1:0] BASE_1S = 2'h2;
  localparam logic [1:0] BASE_1MIN = 2'h3;

  // Base chosen with select low (A) and high (B), two bits per counter, counter 0 lowest.
  localparam logic [7:0] BASE_A_MAP = {BASE_17MS, BASE_3MS, BASE_1S, BASE_3MS};
  localparam logic [7:0] BASE_B_MAP = {BASE_1MIN, BASE_1S, BASE_1MIN, BASE_17MS};

  // Interrupt priority level per counter, 1 is highest.
  localparam logic [7:0] LEVEL_MAP = {2'h3, 2'h2, 2'h1, 2'h1};

  // Mains pulses per second and BCD limits.
  localparam logic [5:0] MAINS_LAST = 6'h3b;
  localparam logic [5:0] MAINS_ZERO = 6'h00;
  localparam logic [3:0] BCD_ZERO = 4'h0;
  localparam logic [3:0] BCD_NINE = 4'h9;
  localparam logic [3:0] MIN_TENS_MAX = 4'h5;
  localparam logic [3:0] MIN_UNITS_TOP = 4'h9;
  localparam logic [3:0] HOUR_TENS_MAX = 4'h2;
  localparam logic [3:0] HOUR_UNITS_TOP = 4'h3;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ---- elapsed_counter.sv ----
// One presettable elapsed-time down counter with a sticky completion flag.
`timescale 1ns/1ps
module elapsed_counter (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic resetn,
  // Preset and time base.
  input wire logic presetStrobe,
  input wire logic [timekeeping_pkg::COUNT_W-1:0] presetValue,
  input wire logic tick,
  // State.
  output logic [timekeeping_pkg::COUNT_W-1:0] count_q,
  output logic done_q,
  output logic doneSet
);

  logic [timekeeping_pkg::COUNT_W-1:0] count_d;
  logic done_d;

  always_comb begin
    count_d = count_q;
    done_d = done_q;
    doneSet = 1'b0;
    if (presetStrobe) begin
      count_d = presetValue;
      done_d = (presetValue == timekeeping_pkg::COUNT_RESET);
      doneSet = done_d;
    end else if (tick && !done_q) begin
      count_d = count_q - {{(timekeeping_pkg::COUNT_W-1){1'b0}}, 1'b1};
      if (count_d == timekeeping_pkg::COUNT_RESET) begin
        done_d = 1'b1;
        doneSet = 1'b1;
      end
    end
  end

  // A counter out of reset reads as finished until it is first preset.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      count_q <= timekeeping_pkg::COUNT_RESET;
      done_q <= 1'b1;
    end else begin
      count_q <= count_d;
      done_q <= done_d;
    end
  end

endmodule // elapsed_counter

// ---- program_timekeeping_unit.sv ----
// Elapsed-time counters and BCD time-of-day clock behind an AXI4-Lite slave.
// Overview of operation
// - Four independent 8-bit counters, preset by program.
// - Counters step once per selected time-base increment.
// - Each time base feeds exactly two counters.
// - Preset command loads counter from accumulator value.
// - Per-counter branch test reports interval ended.
// - Preset chooses whether counter completion interrupts.
// - Interrupt honoured by enabled level, highest first.
// - Clock keeps 24-hour time, wraps at midnight.
// - Sixty mains pulses advance seconds by one.
// - Time shown as six BCD digits.
// - One read transfers whole time value.
// - Electronic reset clears seconds for synchronising.
// - Manual step inputs advance hours and minutes.
// - Read-valid condition tested by branch command.
//
// Chosen here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module program_timekeeping_unit (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic resetn,
  // AXI4-Lite write address and data.
  input wire logic [timekeeping_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [timekeeping_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read.
  input wire logic [timekeeping_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [timekeeping_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Time-base increment pulses.
  input wire logic tick3ms,
  input wire logic tick17ms,
  input wire logic tick1s,
  input wire logic tick1min,
  // Time-of-day inputs.
  input wire logic mainsPulse,
  input wire logic secondsReset,
  input wire logic hourStep,
  input wire logic minuteStep,
  // Status outputs.
  output logic timeReadValid,
  output logic irq
);

  localparam int N = timekeeping_pkg::NUM_COUNTERS;

  // Bus state.
  logic bvalid_q, bvalid_d;
  logic rvalid_q, rvalid_d;
  logic [1:0] rresp_q, rresp_d;
  logic [1:0] bresp_q, bresp_d;
  logic [timekeeping_pkg::DATA_W-1:0] rdata_q, rdata_d;
  logic wrFire, rdFire, wrAny;

  // Counter control and interrupt state.
  logic [N-1:0] sel_q, sel_d, irqEn_q, irqEn_d;
  logic [N-1:0] status_q, status_d, mask_q, mask_d;
  logic [1:0] level_q, level_d;
  logic [N-1:0] presetStrobe, cntTick, cntDone, cntDoneSet, allowed;
  logic [timekeeping_pkg::COUNT_W-1:0] cntValue [N];
  logic [timekeeping_pkg::NUM_BASES-1:0] bases;
  logic [2:0] vecIndex;
  logic vecValid;
  logic [1:0] bestLevel;

  // Time-of-day state.
  logic [5:0] presc_q, presc_d;
  logic [3:0] hT_q, hU_q, mT_q, mU_q, sT_q, sU_q;
  logic [3:0] hT_d, hU_d, mT_d, mU_d, sT_d, sU_d;
  logic secTick, secClear, minCarry, hourCarry, minAdvance, hourAdvance;
  logic [8:0] secNext, minNext, hourNext;

  // Advances a BCD pair; returns wrap flag, tens and units.
  function automatic logic [8:0] bcdInc(input logic [3:0] tens, input logic [3:0] units,
                                        input logic [3:0] tensMax, input logic [3:0] unitsTop);
    logic [8:0] r;
    r = {1'b0, tens, units};
    if (tens == tensMax && units == unitsTop) begin
      r = {1'b1, timekeeping_pkg::BCD_ZERO, timekeeping_pkg::BCD_ZERO};
    end else if (units == timekeeping_pkg::BCD_NINE) begin
      r = {1'b0, tens + 4'h1, timekeeping_pkg::BCD_ZERO};
    end else begin
      r = {1'b0, tens, units + 4'h1};
    end
    return r;
  endfunction

  // Write takes address and data together; read takes one address at a time.
  assign wrFire = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
  assign rdFire = s_axi_arvalid && !rvalid_q;
  assign wrAny = wrFire && (s_axi_wstrb != 4'h0);
  assign s_axi_awready = wrFire;
  assign s_axi_wready = wrFire;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  assign bases = {tick1min, tick1s, tick17ms, tick3ms};

  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_cnt
      assign presetStrobe[gi] = wrAny &&
        (s_axi_awaddr == timekeeping_pkg::OFS_PRESET0 + 8'(4 * gi));
      assign cntTick[gi] = sel_q[gi] ? bases[timekeeping_pkg::BASE_B_MAP[2*gi +: 2]]
                                     : bases[timekeeping_pkg::BASE_A_MAP[2*gi +: 2]];
      elapsed_counter u_counter (
        .core_clk(core_clk),
        .resetn(resetn),
        .presetStrobe(presetStrobe[gi]),
        .presetValue(s_axi_wdata[timekeeping_pkg::COUNT_W-1:0]),
        .tick(cntTick[gi]),
        .count_q(cntValue[gi]),
        .done_q(cntDone[gi]),
        .doneSet(cntDoneSet[gi])
      );
      assign allowed[gi] = (timekeeping_pkg::LEVEL_MAP[2*gi +: 2] <= level_q);
    end
  endgenerate

  // Control and interrupt registers.
  always_comb begin
    sel_d = sel_q;
    irqEn_d = irqEn_q;
    mask_d = mask_q;
    level_d = level_q;
    status_d = status_q;
    for (int i = 0; i < N; i++) begin
      if (presetStrobe[i]) begin
        sel_d[i] = s_axi_wdata[timekeeping_pkg::PRESET_SEL_BIT];
        irqEn_d[i] = s_axi_wdata[timekeeping_pkg::PRESET_IRQ_BIT];
      end
    end
    if (wrAny && s_axi_awaddr == timekeeping_pkg::OFS_IRQ_MASK) begin
      mask_d = s_axi_wdata[N-1:0];
    end
    if (wrAny && s_axi_awaddr == timekeeping_pkg::OFS_LEVEL_ENABLE) begin
      level_d = s_axi_wdata[1:0];
    end
    if (wrAny && s_axi_awaddr == timekeeping_pkg::OFS_IRQ_STATUS) begin
      status_d = status_q & ~s_axi_wdata[N-1:0];
    end
    for (int i = 0; i < N; i++) begin
      if (cntDoneSet[i] && irqEn_d[i]) begin
        status_d[i] = 1'b1;
      end
    end
  end

  always_comb begin
    vecIndex = 3'h0;
    vecValid = 1'b0;
    bestLevel = 2'h3;
    for (int i = N - 1; i >= 0; i--) begin
      if (status_q[i] && mask_q[i] && allowed[i] &&
          (!vecValid || timekeeping_pkg::LEVEL_MAP[2*i +: 2] <= bestLevel)) begin
        vecIndex = 3'(i);
        vecValid = 1'b1;
        bestLevel = timekeeping_pkg::LEVEL_MAP[2*i +: 2];
      end
    end
  end

  assign irq = vecValid;

  // Time of day.
  assign secClear = secondsReset ||
    (wrAny && s_axi_awaddr == timekeeping_pkg::OFS_CLOCK_CTRL &&
     s_axi_wdata[timekeeping_pkg::CLOCK_SECRESET_BIT]);
  assign secTick = mainsPulse && (presc_q == timekeeping_pkg::MAINS_LAST) && !secClear;
  assign secNext = bcdInc(sT_q, sU_q, timekeeping_pkg::MIN_TENS_MAX,
                          timekeeping_pkg::MIN_UNITS_TOP);
  assign minNext = bcdInc(mT_q, mU_q, timekeeping_pkg::MIN_TENS_MAX,
                          timekeeping_pkg::MIN_UNITS_TOP);
  assign hourNext = bcdInc(hT_q, hU_q, timekeeping_pkg::HOUR_TENS_MAX,
                           timekeeping_pkg::HOUR_UNITS_TOP);
  assign minCarry = secTick && secNext[8];
  assign minAdvance = minCarry || minuteStep;
  assign hourCarry = minCarry && minNext[8];
  assign hourAdvance = hourCarry || hourStep;
  assign timeReadValid = !(secTick || secClear || minuteStep || hourStep);

  always_comb begin
    presc_d = presc_q;
    {sT_d, sU_d} = {sT_q, sU_q};
    {mT_d, mU_d} = {mT_q, mU_q};
    {hT_d, hU_d} = {hT_q, hU_q};
    if (secClear) begin
      presc_d = timekeeping_pkg::MAINS_ZERO;
      sT_d = timekeeping_pkg::BCD_ZERO;
      sU_d = timekeeping_pkg::BCD_ZERO;
    end else if (mainsPulse) begin
      presc_d = secTick ? timekeeping_pkg::MAINS_ZERO : presc_q + 6'h01;
    end
    if (secTick) begin
      {sT_d, sU_d} = secNext[7:0];
    end
    if (minAdvance) begin
      {mT_d, mU_d} = minNext[7:0];
    end
    if (hourAdvance) begin
      {hT_d, hU_d} = hourNext[7:0];
    end
  end

  // Bus answers and read mux.
  always_comb begin
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (wrFire) begin
      bvalid_d = 1'b1;
      bresp_d = (s_axi_awaddr <= timekeeping_pkg::OFS_CLOCK_CTRL &&
                 s_axi_awaddr[1:0] == 2'h0 && s_axi_awaddr != timekeeping_pkg::OFS_BRANCH &&
                 s_axi_awaddr != timekeeping_pkg::OFS_TIME &&
                 s_axi_awaddr != timekeeping_pkg::OFS_VECTOR) ?
                timekeeping_pkg::RESP_OKAY : timekeeping_pkg::RESP_SLVERR;
    end
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (rdFire) begin
      rvalid_d = 1'b1;
      rresp_d = timekeeping_pkg::RESP_OKAY;
      rdata_d = '0;
      case (s_axi_araddr)
        timekeeping_pkg::OFS_PRESET0, timekeeping_pkg::OFS_PRESET1,
        timekeeping_pkg::OFS_PRESET2, timekeeping_pkg::OFS_PRESET3: begin
          rdata_d[timekeeping_pkg::COUNT_W-1:0] = cntValue[s_axi_araddr[3:2]];
          rdata_d[timekeeping_pkg::PRESET_SEL_BIT] = sel_q[s_axi_araddr[3:2]];
          rdata_d[timekeeping_pkg::PRESET_IRQ_BIT] = irqEn_q[s_axi_araddr[3:2]];
          rdata_d[timekeeping_pkg::PRESET_DONE_BIT] = cntDone[s_axi_araddr[3:2]];
        end
        timekeeping_pkg::OFS_BRANCH: begin
          rdata_d[N-1:0] = cntDone;
          rdata_d[timekeeping_pkg::BRANCH_VALID_BIT] = timeReadValid;
        end
        timekeeping_pkg::OFS_TIME: begin
          rdata_d[23:0] = {hT_q, hU_q, mT_q, mU_q, sT_q, sU_q};
        end
        timekeeping_pkg::OFS_IRQ_STATUS: rdata_d[N-1:0] = status_q;
        timekeeping_pkg::OFS_IRQ_MASK: rdata_d[N-1:0] = mask_q;
        timekeeping_pkg::OFS_LEVEL_ENABLE: rdata_d[1:0] = level_q;
        timekeeping_pkg::OFS_VECTOR: begin
          rdata_d[2:0] = vecIndex;
          rdata_d[timekeeping_pkg::VECTOR_VALID_BIT] = vecValid;
        end
        timekeeping_pkg::OFS_CLOCK_CTRL: rdata_d = '0;
        default: rresp_d = timekeeping_pkg::RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= timekeeping_pkg::RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= timekeeping_pkg::RESP_OKAY;
      rdata_q <= '0;
      sel_q <= '0;
      irqEn_q <= '0;
      status_q <= '0;
      mask_q <= timekeeping_pkg::MASK_RESET;
      level_q <= timekeeping_pkg::LEVEL_RESET;
      presc_q <= timekeeping_pkg::MAINS_ZERO;
      {hT_q, hU_q, mT_q, mU_q, sT_q, sU_q} <= '0;
    end else begin
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      sel_q <= sel_d;
      irqEn_q <= irqEn_d;
      status_q <= status_d;
      mask_q <= mask_d;
      level_q <= level_d;
      presc_q <= presc_d;
      {hT_q, hU_q, mT_q, mU_q, sT_q, sU_q} <= {hT_d, hU_d, mT_d, mU_d, sT_d, sU_d};
    end
  end

endmodule // program_timekeeping_unit

// ---- ptu_assertions.sv ----
// Port checker for the program timekeeping unit.
`timescale 1ns/1ps
module ptu_assertions (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic resetn,
  // Register bus.
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Time inputs and status.
  input wire logic tick3ms,
  input wire logic tick17ms,
  input wire logic tick1s,
  input wire logic tick1min,
  input wire logic secondsReset,
  input wire logic hourStep,
  input wire logic minuteStep,
  input wire logic timeReadValid,
  input wire logic irq
);
  logic cause_d;
  logic cause_q;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // An interrupt may only rise one cycle after a tick or an accepted write.
  always_comb cause_d = tick3ms | tick17ms | tick1s | tick1min | s_axi_awready;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) cause_q <= 1'b0;
    else cause_q <= cause_d;
  end
  sequence s_wr_take;
    s_axi_awvalid && s_axi_wvalid && s_axi_awready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_wr_ans;
    s_wr_take |=> s_axi_bvalid;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write not answered");
  property p_wr_pair;
    s_axi_wready == s_axi_awready && s_axi_awready == (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid);
  endproperty
  a_wr_pair: assert property (p_wr_pair) else $error("write ready wrong");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("response dropped");
  property p_rd_ans;
    s_rd_take |=> s_axi_rvalid;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  property p_rd_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
  property p_ar_ready;
    s_axi_arready == !s_axi_rvalid;
  endproperty
  a_ar_ready: assert property (p_ar_ready) else $error("read ready wrong");
  property p_clr_busy;
    secondsReset |-> !timeReadValid;
  endproperty
  a_clr_busy: assert property (p_clr_busy) else $error("valid during clear");
  property p_step_busy;
    hourStep || minuteStep |-> !timeReadValid;
  endproperty
  a_step_busy: assert property (p_step_busy) else $error("valid during step");
  property p_irq_cause;
    $rose(irq) |-> cause_q;
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without cause");
endmodule // ptu_assertions

bind program_timekeeping_unit ptu_assertions u_chk (
  .core_clk, .resetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .tick3ms, .tick17ms, .tick1s, .tick1min,
  .secondsReset, .hourStep, .minuteStep, .timeReadValid, .irq
);

// ---- cpu_model.sv ----
// Processor model acting as the bus master.
`timescale 1ns/1ps
module cpu_model (
  // Clock.
  input wire logic core_clk,
  // Write channels.
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  // Read channels.
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  int lag = 0;
  initial begin
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic awDone;
    logic wDone;
    awDone = 1'b0;
    wDone = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    // Each channel is released at the edge that takes it, in whichever order.
    while (!(awDone && wDone)) begin
      @(posedge core_clk);
      if (!awDone && s_axi_awready) begin
        awDone = 1'b1;
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (!wDone && s_axi_wready) begin
        wDone = 1'b1;
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
    end
    repeat (lag) @(posedge core_clk);
    s_axi_bready <= 1'b1;
    do @(posedge core_clk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge core_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~a;
    repeat (lag) @(posedge core_clk);
    s_axi_rready <= 1'b1;
    do @(posedge core_clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask
endmodule // cpu_model

// ---- tb_program_timekeeping_unit.sv ----
// Self-checking bench for the program timekeeping unit.
`timescale 1ns/1ps
module tb_program_timekeeping_unit;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] s_axi_awaddr, s_axi_araddr, pin, v;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, timeReadValid, irq;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [31:0] seed = 32'h1937;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [33:0] q[$];
  logic [1:0] baseTab [8] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h2, 2'h1, 2'h3};
  int nErrors = 0;
  int checked = 0;
  wire tick3ms = pin[0], tick17ms = pin[1], tick1s = pin[2], tick1min = pin[3];
  wire mainsPulse = pin[4], secondsReset = pin[5], hourStep = pin[6], minuteStep = pin[7];
  program_timekeeping_unit uut (.*);
  cpu_model u_cpu (.*);
  initial forever #10 core_clk = ~core_clk;
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic chk(input string n, input logic [33:0] s, input logic [33:0] e);
    checked++;
    if (s !== e) begin
      nErrors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checked, nErrors);
    if (nErrors == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic rx(input logic [7:0] a, input logic [33:0] e);
    q.push_back(e);
    u_cpu.rd(a);
  endtask
  task automatic wx(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    u_cpu.wr(a, d, resp);
    chk("bresp", {32'h0, resp}, {32'h0, e});
  endtask
  task automatic pulse(input int i, input int n);
    repeat (n) begin
      pin[i] <= 1'b1;
      @(posedge core_clk);
      pin[i] <= 1'b0;
      @(posedge core_clk);
    end
  endtask
  // Each completed read takes the oldest expected word.
  always @(posedge core_clk) begin
    if (s_axi_rvalid && s_axi_rready) chk("read", {s_axi_rresp, s_axi_rdata}, q.pop_front());
  end
  initial begin
    repeat (40000) @(posedge core_clk);
    nErrors++;
    tally_and_finish();
  end
  initial begin
    pin = 8'h00;
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    rx(8'h00, {2'h0, 32'h0001_0000});
    rx(8'h14, 34'h0);
    rx(8'h2c, {timekeeping_pkg::RESP_SLVERR, 32'h0});
    wx(8'h10, 32'h1, timekeeping_pkg::RESP_SLVERR);
    for (int c = 0; c < 4; c++) begin
      for (int s = 0; s < 2; s++) begin
        seed = xs(seed);
        v = 8'h2 + {5'h0, seed[2:0]};
        u_cpu.lag = int'(seed[9:8]);
        wx(8'(4 * c), {22'h0, 1'b0, s[0], v}, timekeeping_pkg::RESP_OKAY);
        pulse(int'(baseTab[2 * c + s]), 1);
        for (int k = 0; k < 4; k++) if (k != int'(baseTab[2 * c + s])) pulse(k, 1);
        rx(8'(4 * c), {2'h0, 23'h0, s[0], v - 8'h1});
      end
    end
    // Later pulses must not finish counters 1 to 3; park them far from zero on slow bases.
    for (int c = 1; c < 4; c++) wx(8'(4 * c), 32'h0000_01ff, timekeeping_pkg::RESP_OKAY);
    wx(8'h1c, 32'hf, timekeeping_pkg::RESP_OKAY);
    wx(8'h20, 32'h1, timekeeping_pkg::RESP_OKAY);
    wx(8'h00, 32'h0000_0202, timekeeping_pkg::RESP_OKAY);
    pulse(0, 5);
    rx(8'h00, {2'h0, 32'h0001_0200});
    rx(8'h10, {2'h0, 32'h11});
    rx(8'h24, {2'h0, 32'h8});
    chk("irq", {33'h0, irq}, 34'h1);
    wx(8'h04, 32'h0, timekeeping_pkg::RESP_OKAY);
    wx(8'h08, 32'h0000_0200, timekeeping_pkg::RESP_OKAY);
    rx(8'h18, {2'h0, 32'h5});
    wx(8'h18, 32'h1, timekeeping_pkg::RESP_OKAY);
    chk("irq", {33'h0, irq}, 34'h0);
    wx(8'h20, 32'h2, timekeeping_pkg::RESP_OKAY);
    rx(8'h24, {2'h0, 32'ha});
    wx(8'h1c, 32'h0, timekeeping_pkg::RESP_OKAY);
    chk("irq", {33'h0, irq}, 34'h0);
    pulse(4, 60);
    rx(8'h14, {2'h0, 32'h1});
    wx(8'h28, 32'h1, timekeeping_pkg::RESP_OKAY);
    rx(8'h14, 34'h0);
    pulse(4, 60);
    pulse(5, 1);
    rx(8'h14, 34'h0);
    pulse(6, 23);
    pulse(7, 59);
    pulse(4, 59 * 60);
    rx(8'h14, {2'h0, 32'h0023_5959});
    pulse(4, 60);
    rx(8'h14, 34'h0);
    @(posedge core_clk);
    chk("pending", 34'(q.size()), 34'h0);
    tally_and_finish();
  end
endmodule // tb_program_timekeeping_unit
